// *** dv/ifd_core_properties.sv ***
// port-level checks of the instruction format decoder
`timescale 1ns/1ps
module ifd_core_properties
    import ifd_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic [15:0] instr_word,
    input wire logic        instr_valid,
    input wire logic        cond_true,
    input wire logic        ext_enable,
    input wire logic [3:0]  bank_select_register,
    input wire logic        instr_ack,
    input wire logic [1:0]  q_phase,
    input wire logic        issue_q,
    input wire logic        nop_cycle_q,
    input wire ifd_dec_t    dec_q,
    input wire logic [11:0] eff_addr_q,
    input wire logic        to_working_register_q,
    input wire logic        to_file_q,
    input wire logic [1:0]  ins_cycles_q,
    input wire logic        word2_bad_q
);
    // ********
    // checks
    // ********
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    chk_phase_step: assert property (1'b1 |=> q_phase == $past(q_phase) + 2'd1)
        else $error("phase did not step");
    chk_issue_ack: assert property (issue_q |-> $past(instr_ack) && q_phase == 2'd1)
        else $error("issue without a taken word");
    chk_nop_phase: assert property (nop_cycle_q |-> q_phase == 2'd1 && !issue_q)
        else $error("idle cycle misplaced");
    chk_dest_only: assert property ((to_working_register_q || to_file_q) |-> issue_q && dec_q.has_d)
        else $error("destination pulse without issue");
    chk_dest_sel: assert property (issue_q && dec_q.has_d |->
        to_file_q == dec_q.d && to_working_register_q == !dec_q.d)
        else $error("wrong destination");
    chk_access_bank: assert property (issue_q && dec_q.cls inside {CLS_BYTE, CLS_BIT} &&
        !dec_q.a |-> eff_addr_q == {(dec_q.f >= ACCESS_SPLIT) ? ACCESS_HI_BANK
        : ACCESS_LO_BANK, dec_q.f})
        else $error("access bank address wrong");
    chk_bank_reg: assert property (issue_q && dec_q.cls inside {CLS_BYTE, CLS_BIT} &&
        dec_q.a |-> eff_addr_q == {bank_select_register, dec_q.f})
        else $error("banked address wrong");
    chk_dec_hold: assert property (!issue_q |-> $stable(dec_q) && $stable(eff_addr_q))
        else $error("decode changed without issue");
    chk_one_issue: assert property (issue_q |=> !issue_q [*3])
        else $error("two issues in one cycle");
    chk_two_cycles: assert property (issue_q && dec_q.two_word |->
        ins_cycles_q == 2'd2 && $past(instr_ack, 5))
        else $error("double word timing wrong");

    cov_two_word: cover property (issue_q && dec_q.two_word);
    cov_nop: cover property (nop_cycle_q);
    cov_to_file: cover property (to_file_q);
    cov_banked: cover property (issue_q && dec_q.a);
endmodule : ifd_core_properties

bind ifd_core ifd_core_properties ifd_core_properties_inst (.clk_sys, .rst_n, .instr_word,
    .instr_valid, .cond_true, .ext_enable, .bank_select_register, .instr_ack, .q_phase,
    .issue_q, .nop_cycle_q, .dec_q, .eff_addr_q, .to_working_register_q, .to_file_q,
    .ins_cycles_q, .word2_bad_q);

// *** dv/ifd_progmem.sv ***
// program memory model handing one word per instruction cycle
`timescale 1ns/1ps
module ifd_progmem
    import ifd_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic [1:0] q_phase,
    output logic [15:0]     instr_word,
    output logic            instr_valid
);
    // ********
    // word queue
    // ********
    logic [15:0] mem_q[$];
    logic        take;

    initial begin
        instr_word = 16'h0000;
        instr_valid = 1'b0;
        take = 1'b0;
    end

    task automatic put(input logic [15:0] w);
        mem_q.push_back(w);
    endtask : put

    // a word leaves only after a cycle-start edge; an idle bus toggles so stale data shows
    always @(negedge clk_sys) begin
        if (take) begin
            void'(mem_q.pop_front());
        end
        if (mem_q.size() > 0) begin
            instr_valid <= 1'b1;
            instr_word <= mem_q[0];
        end else begin
            instr_valid <= 1'b0;
            instr_word <= ~instr_word;
        end
        take = rst_n && q_phase == 2'd0 && mem_q.size() > 0;
    end
endmodule : ifd_progmem

// *** dv/testbench.sv ***
// self-checking bench for the instruction format decoder
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench
    import ifd_pkg::*;
;
    localparam logic [51:0] NOPN = {1'b1, 51'h0};
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        cond_true = 1'b0;
    logic        ext_enable = 1'b0;
    logic [3:0]  bank_select_register = 4'h0;
    logic [15:0] instr_word;
    logic        instr_valid;
    logic        instr_ack;
    logic [1:0]  q_phase;
    logic        issue_q;
    logic        nop_cycle_q;
    ifd_dec_t    dec_q;
    logic [11:0] eff_addr_q;
    logic        to_working_register_q;
    logic        to_file_q;
    logic [1:0]  ins_cycles_q;
    logic        word2_bad_q;
    logic [51:0] notes[$];
    logic [51:0] exp_n;
    logic [27:0] act;
    logic        flush = 1'b0;
    int          n_errors = 0;
    int          total_checks = 0;

    ifd_core ifd_core_inst (.clk_sys, .rst_n, .instr_word, .instr_valid, .cond_true, .ext_enable,
        .bank_select_register, .instr_ack, .q_phase, .issue_q, .nop_cycle_q, .dec_q, .eff_addr_q,
        .to_working_register_q, .to_file_q, .ins_cycles_q, .word2_bad_q);
    ifd_progmem ifd_progmem_inst (.clk_sys, .rst_n, .q_phase, .instr_word, .instr_valid);

    always #4 clk_sys = ~clk_sys;

    // ********
    // helpers
    // ********
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [11:0] ea(input logic a, input logic [7:0] f);
        if (a) begin
            return {bank_select_register, f};
        end
        return {(f >= ACCESS_SPLIT) ? ACCESS_HI_BANK : ACCESS_LO_BANK, f};
    endfunction : ea

    function automatic logic [51:0] iss(input ifd_cls_t c, input logic [23:0] k,
                                        input logic [23:0] m);
        return {1'b0, c, k, m};
    endfunction : iss

    // fields compared per class; the note's mask drops fields an opcode leaves open
    function automatic logic [23:0] key();
        case (dec_q.cls)
            CLS_BYTE: return {8'h00, eff_addr_q, to_working_register_q, to_file_q, ins_cycles_q};
            CLS_BIT:  return {9'h000, dec_q.b, eff_addr_q};
            CLS_LIT:  return {12'h000, dec_q.file_select_pointer, dec_q.k, dec_q.two_word, 1'b0};
            CLS_CTRL: return {dec_q.n[17:0], dec_q.s, dec_q.m, dec_q.two_word, ins_cycles_q};
            default:  return 24'h000000;
        endcase
    endfunction : key

    task automatic put(input logic [15:0] w, input logic [51:0] n);
        ifd_progmem_inst.put(w);
        notes.push_back(flush ? NOPN : n);
        flush = 1'b0;
    endtask : put

    task automatic put2(input logic [15:0] w1, input logic [15:0] w2, input logic [51:0] n);
        ifd_progmem_inst.put(w1);
        ifd_progmem_inst.put(w2);
        if (flush) begin
            notes.push_back(NOPN);
        end
        notes.push_back(flush ? NOPN : n);
        flush = 1'b0;
    endtask : put2

    task automatic summarize();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    always @(negedge clk_sys) begin
        if (rst_n && (issue_q || nop_cycle_q) && notes.size() > 0) begin
            exp_n = notes.pop_front();
            act = nop_cycle_q ? 28'h8000000 : {1'b0, dec_q.cls, key() & exp_n[23:0]};
            `CHK(act, exp_n[51:24])
            `CHK(word2_bad_q, 1'b0)
        end
    end

    // ********
    // stimulus
    // ********
    initial begin
        logic [31:0] r;
        int          i;
        int          k;
        r = 32'h0000FD0C;
        repeat (8) @(negedge clk_sys);
        rst_n = 1'b1;
        for (i = 0; i < 24; i++) begin
            r = lfsr(r);
            bank_select_register = r[3:0];
            cond_true = r[4];
            ext_enable = r[5];
            for (k = 0; k < 8 && q_phase != 2'd2; k++) @(negedge clk_sys);
            put({6'h09, r[6], r[7], r[15:8]}, iss(CLS_BYTE,
                {8'h00, ea(r[7], r[15:8]), !r[6], r[6], 2'd1}, '1));
            put({4'h8, r[18:16], r[19], r[31:24]},
                iss(CLS_BIT, {9'h000, r[18:16], ea(r[19], r[31:24])}, '1));
            put({8'h0E, r[23:16]}, iss(CLS_LIT, {14'h0000, r[23:16], 2'b00}, 24'hFFF3FF));
            put2({OP_LFSR, r[21:20], r[11:8]}, {8'hF0, r[31:24]},
                iss(CLS_LIT, {12'h000, r[21:20], r[31:24], 2'b10}, '1));
            put({8'hE8, 2'b00, r[21:16]}, ext_enable ? iss(CLS_EXT, 24'h0, '1) : NOPN);
            put({OP_BTFSS, r[18:16], r[19], r[15:8]},
                iss(CLS_BIT, {9'h000, r[18:16], ea(r[19], r[15:8])}, '1));
            flush = cond_true;
            put2({OP_GOTO, r[7:0]}, {4'hF, r[19:8]},
                iss(CLS_CTRL, {r[17:8], r[7:0], 6'h06}, 24'hFFFFC7));
            put2({OP_CALL, i[0], r[31:24]}, {4'hF, r[11:0]},
                iss(CLS_CTRL, {r[9:0], r[31:24], i[0], 5'h06}, 24'hFFFFE7));
            put({4'hF, r[27:16]}, NOPN);
            put({OP_RETURN, i[1]}, iss(CLS_CTRL, {18'h0, i[1], 5'h02}, 24'h000027));
            flush = 1'b1;
            put({8'h0E, r[7:0]}, NOPN);
            put({OP_TBL, i[2], i[1:0]}, iss(CLS_CTRL, {19'h0, i[1:0], 3'h2}, 24'h00001F));
            flush = 1'b1;
            put({8'h0E, r[15:8]}, NOPN);
            put({OP_BRA, 2'b00, r[9:0]}, iss(CLS_CTRL, 24'h000002, 24'h000007));
            flush = 1'b1;
            put({8'h0E, r[23:16]}, NOPN);
            for (k = 0; k < 400 && notes.size() > 0; k++) @(negedge clk_sys);
            if (notes.size() > 0) begin
                n_errors++;
                summarize();
            end
        end
        summarize();
    end
endmodule : testbench

// *** rtl/ifd_core.sv ***
// instruction word decoder and instruction-cycle sequencer
// Operation
// - recognise 75 base instructions plus 8 extended-set instructions
// - every instruction is one 16-bit word except four base double-word ones and m_movsx when the extended set is on
// - split each single word into opcode and operand fields
// - byte instructions carry file number, destination and access selector
// - destination zero writes working register, one writes the file register
// - bit instructions carry file number, bit number and access selector
// - literal instructions carry a literal, a pointer select, or nothing
// - control instructions carry address, call/return mode, table mode or nothing
// - second word has top four bits ones and alone executes as no-op
// - single word takes one cycle, two when taken, changing program counter or a table operation
// - double-word instructions take two instruction cycles
// - one instruction cycle spans four oscillator periods
// - access selector zero uses access bank, one uses bank select register
`timescale 1ns/1ps
module ifd_core
    import ifd_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [15:0] instr_word,
    input  wire logic        instr_valid,
    input  wire logic        cond_true,
    input  wire logic        ext_enable,
    input  wire logic [3:0]  bank_select_register,
    output logic             instr_ack,
    output logic [1:0]       q_phase,
    output logic             issue_q,
    output logic             nop_cycle_q,
    output ifd_dec_t         dec_q,
    output logic [11:0]      eff_addr_q,
    output logic             to_working_register_q,
    output logic             to_file_q,
    output logic [1:0]       ins_cycles_q,
    output logic             word2_bad_q
);

    // ************************************************************
    // instruction cycle framing
    // ************************************************************
    logic cyc_start;

    ifd_qphase #(.PHASES(Q_PER_CYCLE)) u_qphase (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .q_phase   (q_phase),
        .cyc_start (cyc_start)
    );

    // ************************************************************
    // opcode field matches
    // ************************************************************
    logic [15:0] w;
    logic [3:0]  hi4;

    assign w   = instr_word;
    assign hi4 = w[15:12];

    logic m_misc, m_movlb, m_lit8, m_retlw, m_mulwf, m_decf;
    logic m_byte, m_byte6, m_bcond_skip, m_bit, m_bit_skip;
    logic m_movff, m_bra, m_bcond, m_call, m_lfsr, m_goto;
    logic m_xfsr, m_pushl, m_movsx, m_callw, m_ext;
    logic m_ret, m_reset, m_tbl, m_word2;

    assign m_misc   = (w[15:8] == OP_MISC);
    assign m_movlb  = (w[15:4] == OP_MOVLB);
    assign m_lit8   = (w[15:11] == OP_LIT8);
    assign m_retlw  = m_lit8 && (w[10:8] == OP_RETLW);
    assign m_mulwf  = (w[15:9] == OP_MULWF);
    assign m_decf   = (w[15:10] == OP_DECF);
    assign m_byte6  = (hi4 == OP_BYTE6);
    assign m_byte   = m_mulwf || m_decf || m_byte6
                    || (hi4 != 4'h0 && hi4 < OP_BYTE6);
    assign m_bcond_skip = (w[15:10] == OP_DECFSZ) || (w[15:10] == OP_INCFSZ)
                        || (w[15:10] == OP_DCFSNZ) || (w[15:10] == OP_INFSNZ)
                        || (w[15:11] == OP_CPFS);
    assign m_bit    = (hi4 >= OP_BIT_LO) && (hi4 <= OP_BIT_HI);
    assign m_bit_skip = m_bit && (hi4 >= OP_BTFSS);
    assign m_movff  = (hi4 == OP_MOVFF);
    assign m_bra    = (hi4 == OP_BRA);
    assign m_bcond  = (w[15:11] == OP_BCOND);
    assign m_call   = (w[15:9] == OP_CALL);
    assign m_lfsr   = (w[15:6] == OP_LFSR);
    assign m_goto   = (w[15:8] == OP_GOTO);
    assign m_xfsr   = (w[15:9] == OP_XFSR);
    assign m_pushl  = (w[15:8] == OP_PUSHL);
    assign m_movsx  = (w[15:8] == OP_MOVSX);
    assign m_callw  = (w == OP_CALLW);
    // extended opcodes fall back to no-op while the extended set is off
    assign m_ext    = ext_enable && (m_xfsr || m_pushl || m_movsx || m_callw);
    assign m_ret    = (w[15:1] == OP_RETFIE) || (w[15:1] == OP_RETURN);
    assign m_reset  = (w == OP_RESET);
    assign m_tbl    = (w[15:3] == OP_TBL);
    // a lone second word decodes to nothing at all
    assign m_word2  = (hi4 == WORD2_MARK);

    // ************************************************************
    // class and operand extraction
    // ************************************************************
    ifd_dec_t dw;
    logic     lone_ctrl;

    assign lone_ctrl = m_misc && !m_callw;

    assign dw.cls = m_word2 ? CLS_NOP :
                    m_ext   ? CLS_EXT :
                    (m_lit8 || m_movlb || m_lfsr) ? CLS_LIT :
                    (m_bra || m_bcond || m_call || m_goto || lone_ctrl) ? CLS_CTRL :
                    (m_bit) ? CLS_BIT :
                    (m_byte || m_movff) ? CLS_BYTE :
                    CLS_NOP;
    assign dw.f     = w[7:0];
    assign dw.d     = w[9];
    assign dw.has_d = m_byte && !m_byte6 && !m_mulwf;
    assign dw.a     = w[8];
    assign dw.b     = w[11:9];
    assign dw.k     = m_xfsr ? {2'h0, w[5:0]} : (m_lfsr ? {4'h0, w[3:0]} : w[7:0]);
    assign dw.file_select_pointer   = m_xfsr ? w[7:6] : w[5:4];
    // call carries its mode in bit 8, return and the stack returns in bit 0
    assign dw.s     = m_call ? w[8] : w[0];
    assign dw.m     = w[1:0];
    assign dw.n     = m_bra ? {9'h000, w[10:0]} : {12'h000, w[7:0]};
    assign dw.two_word = !m_word2 && (m_movff || m_call || m_lfsr || m_goto
                       || (m_ext && m_movsx));
    assign dw.cond   = !m_word2 && (m_bcond || m_bit_skip || (m_byte && m_bcond_skip));
    assign dw.pc_chg = !m_word2 && (m_bra || m_ret || m_reset || m_retlw
                     || (m_ext && m_callw) || m_call || m_goto);
    assign dw.extra  = m_tbl;

    // ************************************************************
    // cycle sequencer
    // ************************************************************
    typedef enum logic [1:0] { ST_FIRST, ST_WORD2 } ifd_st_t;

    ifd_st_t  st_q, st_d;
    ifd_dec_t hold_q, hold_d;
    logic     flush_q, flush_d;
    logic     pend_q, pend_d;
    logic     take;
    logic     flush_now;
    logic     go_word2;
    logic     issue_d;
    ifd_dec_t out_d;

    assign instr_ack = take;
    assign take      = cyc_start && instr_valid;
    // a taken test squashes the word fetched in the following cycle
    assign flush_now = flush_q || (pend_q && cond_true);
    assign go_word2  = (st_q == ST_FIRST) && take && !flush_now && dw.two_word;

    always_comb begin
        st_d    = st_q;
        hold_d  = hold_q;
        flush_d = flush_q;
        pend_d  = pend_q;
        issue_d = 1'b0;
        out_d   = dw;
        if (cyc_start) begin
            flush_d = 1'b0;
            pend_d  = 1'b0;
            case (st_q)
                ST_FIRST: begin
                    if (take && !flush_now) begin
                        if (dw.two_word) begin
                            hold_d = dw;
                            st_d   = ST_WORD2;
                        end else begin
                            // undecoded and lone second words only show as a no-op cycle
                            issue_d = (dw.cls != CLS_NOP);
                            // single-word jumps cost one extra dead cycle
                            flush_d = dw.pc_chg || dw.extra;
                            pend_d  = dw.cond;
                        end
                    end
                end
                ST_WORD2: begin
                    if (take) begin
                        issue_d = 1'b1;
                        out_d   = hold_q;
                        out_d.n = {w[11:0], hold_q.n[7:0]};
                        if (hold_q.cls == CLS_LIT) begin
                            out_d.k = w[7:0];
                        end
                        // the second word itself is the dead cycle of a jump
                        st_d    = ST_FIRST;
                    end
                end
                default: begin
                    st_d = ST_FIRST;
                end
            endcase
        end
    end

    // ************************************************************
    // destination and bank selection
    // ************************************************************
    logic [11:0] eff_d;
    logic        access_lo;

    assign access_lo = (out_d.f < ACCESS_SPLIT);
    assign eff_d = out_d.a ? {bank_select_register, out_d.f} :
                   {(access_lo ? ACCESS_LO_BANK : ACCESS_HI_BANK), out_d.f};

    logic       working_register_d;
    logic       file_d;
    logic [1:0] cyc_d;
    logic       bad_d;
    logic       nop_d;

    assign working_register_d = issue_d && out_d.has_d && !out_d.d;
    assign file_d = issue_d && out_d.has_d && out_d.d;
    assign cyc_d  = (out_d.two_word || out_d.pc_chg || out_d.extra) ? 2'h2 : 2'h1;
    // skip over a double word: first word flushed, orphan second word is a no-op
    assign nop_d  = cyc_start && (flush_now || !instr_valid
                  || ((st_q == ST_FIRST) && dw.cls == CLS_NOP));
    assign bad_d  = cyc_start && (st_q == ST_WORD2) && take && (hi4 != WORD2_MARK);

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q    <= ST_FIRST;
            hold_q  <= '0;
            flush_q <= 1'b0;
            pend_q  <= 1'b0;
        end else begin
            st_q    <= st_d;
            hold_q  <= hold_d;
            flush_q <= flush_d;
            pend_q  <= pend_d;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            issue_q               <= 1'b0;
            nop_cycle_q           <= 1'b0;
            dec_q                 <= '0;
            eff_addr_q            <= 12'h000;
            to_working_register_q <= 1'b0;
            to_file_q             <= 1'b0;
            ins_cycles_q          <= 2'h0;
            word2_bad_q           <= 1'b0;
        end else begin
            issue_q               <= issue_d;
            nop_cycle_q           <= nop_d && !go_word2;
            to_working_register_q <= working_register_d;
            to_file_q             <= file_d;
            word2_bad_q           <= bad_d;
            if (issue_d) begin
                dec_q        <= out_d;
                eff_addr_q   <= eff_d;
                ins_cycles_q <= cyc_d;
            end
        end
    end

endmodule : ifd_core

// *** rtl/ifd_pkg.sv ***
// shared constants and types for the instruction format decoder
package ifd_pkg;

    // ************************************************************
    // instruction set size and word layout
    // ************************************************************
    localparam int          N_BASE_INSTR   = 75;
    localparam int          N_EXT_INSTR    = 8;
    localparam int          WORD_W         = 16;
    localparam int          N_TWO_WORD     = 4;
    localparam logic [3:0]  WORD2_MARK     = 4'hF;
    localparam int          Q_PER_CYCLE    = 4;
    localparam logic [7:0]  ACCESS_SPLIT   = 8'h80;
    localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
    localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;

    // ************************************************************
    // opcode match values, compared against the upper word bits except OP_RETLW, which is compared against bits 10:8
    // ************************************************************
    localparam logic [7:0]  OP_MISC    = 8'h00;
    localparam logic [11:0] OP_MOVLB   = 12'h010;
    localparam logic [4:0]  OP_LIT8    = 5'h01;
    localparam logic [2:0]  OP_RETLW   = 3'h4;
    localparam logic [6:0]  OP_MULWF   = 7'h01;
    localparam logic [5:0]  OP_DECF    = 6'h01;
    localparam logic [5:0]  OP_DECFSZ  = 6'h0B;
    localparam logic [5:0]  OP_INCFSZ  = 6'h0F;
    localparam logic [5:0]  OP_DCFSNZ  = 6'h13;
    localparam logic [5:0]  OP_INFSNZ  = 6'h12;
    localparam logic [4:0]  OP_CPFS    = 5'h0C;
    localparam logic [3:0]  OP_BYTE6   = 4'h6;
    localparam logic [3:0]  OP_BIT_LO  = 4'h7;
    localparam logic [3:0]  OP_BIT_HI  = 4'hB;
    localparam logic [3:0]  OP_BTFSS   = 4'hA;
    localparam logic [3:0]  OP_MOVFF   = 4'hC;
    localparam logic [3:0]  OP_BRA     = 4'hD;
    localparam logic [4:0]  OP_BCOND   = 5'h1C;
    localparam logic [6:0]  OP_CALL    = 7'h76;
    localparam logic [9:0]  OP_LFSR    = 10'h3B8;
    localparam logic [7:0]  OP_GOTO    = 8'hEF;
    localparam logic [6:0]  OP_XFSR    = 7'h74;
    localparam logic [7:0]  OP_PUSHL   = 8'hEA;
    localparam logic [7:0]  OP_MOVSX   = 8'hEB;
    localparam logic [15:0] OP_CALLW   = 16'h0014;
    localparam logic [14:0] OP_RETFIE  = 15'h0008;
    localparam logic [14:0] OP_RETURN  = 15'h0009;
    localparam logic [15:0] OP_RESET   = 16'h00FF;
    localparam logic [12:0] OP_TBL     = 13'h0001;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [2:0] {
        CLS_NOP, CLS_BYTE, CLS_BIT, CLS_LIT, CLS_CTRL, CLS_EXT
    } ifd_cls_t;

    typedef struct packed {
        ifd_cls_t    cls;
        logic [7:0]  f;
        logic        d;
        logic        has_d;
        logic        a;
        logic [2:0]  b;
        logic [7:0]  k;
        logic [1:0]  file_select_pointer;
        logic        s;
        logic [1:0]  m;
        logic [19:0] n;
        logic        two_word;
        logic        cond;
        logic        pc_chg;
        logic        extra;
    } ifd_dec_t;

endpackage : ifd_pkg

// *** rtl/ifd_qphase.sv ***
// oscillator-period phase counter that frames each instruction cycle
`timescale 1ns/1ps
module ifd_qphase
    import ifd_pkg::*;
#(
    parameter int PHASES = Q_PER_CYCLE
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    output logic [1:0]      q_phase,
    output logic            cyc_start
);

    // ************************************************************
    // elaboration check
    // ************************************************************
    if (PHASES != 4) begin : g_bad
        $error("ifd_qphase: phase counter serves exactly four phases");
    end

    logic [1:0] q_q;
    logic [1:0] q_d;

    assign q_d       = q_q + 2'h1;
    assign q_phase   = q_q;
    assign cyc_start = (q_q == 2'h0);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q_q <= 2'h0;
        end else begin
            q_q <= q_d;
        end
    end

endmodule : ifd_qphase
